/* rtl/intc_pkg.sv */
// Package for the interrupt controller with supply monitor.
// Assumes a single 20 MHz system clock and an 8-bit register port.
package intc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned IRQ_DELAY_NS = 1000;
    localparam int unsigned IRQ_DELAY_CYC =
        (IRQ_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000 < 1 ? 1 :
        (IRQ_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [2:0] A_EDGE = 3'h0;
    localparam logic [2:0] A_CTRL0 = 3'h1;
    localparam logic [2:0] A_CTRL1 = 3'h2;
    localparam logic [2:0] A_CTRL2 = 3'h3;
    localparam logic [2:0] A_CTRL3 = 3'h4;
    localparam logic [2:0] A_MULTI = 3'h5;
    localparam logic [2:0] A_SUPPLY = 3'h6;
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam logic [7:0] EDGE_MASK = 8'h0F;
    localparam logic [7:0] CTRL0_MASK = 8'h7F;
    localparam logic [7:0] MULTI_MASK = 8'h77;
    localparam logic [7:0] SUPPLY_WMASK = 8'h1F;
    localparam int unsigned GIE_BIT = 0;
    localparam int unsigned LVO_BIT = 5;
    localparam int unsigned LVEN_BIT = 4;
    localparam int unsigned BGB_BIT = 3;
    localparam int unsigned NSRC = 16;
    localparam int unsigned VEC_W = 4;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_REQ = 2'h1,
        ST_SERV = 2'h3
    } ack_state_t;

    typedef struct packed {
        logic [7:0] edge_r;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] multi;
        logic [7:0] supply;
        logic [1:0] pin_prev;
        logic lvo_prev;
        logic [15:0] dly_cnt;
        logic dly_run;
        logic [7:0] rdata;
        ack_state_t st;
        logic irq_req;
        logic [3:0] vec;
        logic bandgap_en;
        logic det_on;
    } state_t;
endpackage

/* rtl/intc_supply.sv */
// Interrupt request/enable logic and supply detector control.
// Assumes pin and source inputs synchronous to clock_i, and a CPU
// that acknowledges a vector with a one-cycle pulse.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
module intc_supply #(
    parameter int unsigned DELAY_CYC = intc_pkg::IRQ_DELAY_CYC
) (
    input wire logic clock_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic [2:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after read
    input wire logic ext_irq_pin_0_i, // External pin 0
    input wire logic ext_irq_pin_1_i, // External pin 1
    input wire logic line_comp0_evt_i, // Comparator 0 event pulse
    input wire logic [7:0] ctrl1_evt_i, // Events for control 1 flags
    input wire logic [7:0] ctrl2_evt_i, // Events for control 2 flags
    input wire logic [2:0] ctrl3_evt_i, // Comparator 1, time bases
    input wire logic [2:0] multi_evt_i, // Serial port, timer A, timer P
    input wire logic comp_below_i, // Analogue comparator: supply low
    input wire logic sleep_i, // Device in sleep mode
    input wire logic low_supply_reset_en_i, // Low-supply reset enabled
    input wire logic stack_full_i, // Return stack full
    input wire logic ack_i, // CPU takes the presented vector
    output logic irq_req_o, // Interrupt request to CPU
    output logic [3:0] irq_vec_o, // Vector index of request
    output logic detector_on_o, // Power to detector
    output logic bandgap_en_o, // Bandgap reference enable
    output logic [2:0] threshold_sel_o, // Selected threshold code
    output logic wake_o // Flag newly set, wake request
);
    intc_pkg::state_t q, d;
    intc_pkg::reg_req_t req;
    logic [1:0] pin_now;
    logic [1:0] pin_hit;
    logic [7:0] newf0, newf1, newf2, newf3, newfm;
    logic [15:0] pend;
    logic [3:0] win;
    logic found;
    logic lvf_set;
    logic det_act;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign pin_now = {ext_irq_pin_1_i, ext_irq_pin_0_i};

    // Edge decode per pin
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic [1:0] sel;
            assign sel = q.edge_r[2*g +: 2];
            assign pin_hit[g] =
                (sel[0] & pin_now[g] & ~q.pin_prev[g]) |
                (sel[1] & ~pin_now[g] & q.pin_prev[g]);
        end
    endgenerate

    always_comb begin
        d = q;
        newf0 = 8'h00;
        newf1 = 8'h00;
        newf2 = 8'h00;
        newf3 = 8'h00;
        newfm = 8'h00;
        lvf_set = 1'b0;
        det_act = q.supply[intc_pkg::LVEN_BIT] & ~sleep_i;
        d.det_on = det_act;
        d.bandgap_en = q.supply[intc_pkg::LVEN_BIT] |
            low_supply_reset_en_i | q.supply[intc_pkg::BGB_BIT];
        d.pin_prev = pin_now;
        // Output flag follows comparator while detector active
        d.supply[intc_pkg::LVO_BIT] = det_act & comp_below_i;
        d.lvo_prev = q.supply[intc_pkg::LVO_BIT];
        // Delay restarts on every rise, stops on fall
        if (!q.supply[intc_pkg::LVO_BIT]) begin
            d.dly_run = 1'b0;
            d.dly_cnt = 16'h0000;
        end else if (!q.lvo_prev) begin
            d.dly_run = 1'b1;
            d.dly_cnt = 16'h0000;
        end else if (q.dly_run) begin
            if (q.dly_cnt >= 16'(DELAY_CYC - 1)) begin
                lvf_set = 1'b1;
                d.dly_run = 1'b0;
            end else begin
                d.dly_cnt = q.dly_cnt + 16'h0001;
            end
        end

        // Register writes
        if (req.wr) begin
            case (req.addr)
                intc_pkg::A_EDGE:
                    d.edge_r = req.wdata & intc_pkg::EDGE_MASK;
                intc_pkg::A_CTRL0:
                    d.ctrl0 = req.wdata & intc_pkg::CTRL0_MASK;
                intc_pkg::A_CTRL1: d.ctrl1 = req.wdata;
                intc_pkg::A_CTRL2: d.ctrl2 = req.wdata;
                intc_pkg::A_CTRL3: d.ctrl3 = req.wdata;
                intc_pkg::A_MULTI:
                    d.multi = req.wdata & intc_pkg::MULTI_MASK;
                intc_pkg::A_SUPPLY:
                    d.supply = (req.wdata & intc_pkg::SUPPLY_WMASK) |
                        (d.supply & ~intc_pkg::SUPPLY_WMASK);
                default: ;
            endcase
        end

        // Hardware sets win over software clears
        newf0 = {1'b0, pin_hit[1], pin_hit[0], line_comp0_evt_i,
            4'h0};
        newf1 = {ctrl1_evt_i[7:6], ctrl1_evt_i[5] | lvf_set,
            ctrl1_evt_i[4], 4'h0} & 8'hF0;
        newf2 = ctrl2_evt_i & 8'hF0;
        newfm = {1'b0, multi_evt_i, 4'h0};
        newf3 = {1'b0, ctrl3_evt_i, 4'h0};
        d.ctrl0 = d.ctrl0 | newf0;
        d.ctrl1 = d.ctrl1 | newf1 | {ctrl1_evt_i[7:4], 4'h0} & 8'h00;
        d.ctrl2 = d.ctrl2 | newf2;
        d.multi = d.multi | newfm;
        // Multi-source flag set when any enabled secondary flag is set
        if (|(q.multi[6:4] & q.multi[2:0]))
            newf3[7] = 1'b1;
        d.ctrl3 = d.ctrl3 | newf3;

        // Pending = flag AND own enable, in priority order
        pend = {8'h00,
            q.ctrl3[7] & q.ctrl3[3],
            q.ctrl2[4] & q.ctrl2[0],
            q.ctrl1[5] & q.ctrl1[1],
            q.ctrl3[4] & q.ctrl3[0],
            q.ctrl1[6] & q.ctrl1[2],
            q.ctrl0[4] & q.ctrl0[1],
            q.ctrl0[6] & q.ctrl0[3],
            q.ctrl0[5] & q.ctrl0[2]};
        pend[8] = q.ctrl1[4] & q.ctrl1[0];
        pend[9] = q.ctrl1[7] & q.ctrl1[3];
        pend[10] = q.ctrl2[7] & q.ctrl2[3];
        pend[11] = q.ctrl2[6] & q.ctrl2[2];
        pend[12] = q.ctrl2[5] & q.ctrl2[1];
        pend[13] = q.ctrl3[6] & q.ctrl3[2];
        pend[14] = q.ctrl3[5] & q.ctrl3[1];
        win = 4'h0;
        found = 1'b0;
        for (int i = 0; i < intc_pkg::NSRC; i++) begin
            if (pend[i] && !found) begin
                win = 4'(i);
                found = 1'b1;
            end
        end

        case (q.st)
            intc_pkg::ST_IDLE: begin
                d.irq_req = 1'b0;
                if (found && q.ctrl0[intc_pkg::GIE_BIT]
                        && !stack_full_i) begin
                    d.st = intc_pkg::ST_REQ;
                    d.irq_req = 1'b1;
                    d.vec = win;
                end
            end
            intc_pkg::ST_REQ: begin
                if (!q.ctrl0[intc_pkg::GIE_BIT] || stack_full_i) begin
                    d.st = intc_pkg::ST_IDLE;
                    d.irq_req = 1'b0;
                end else if (ack_i) begin
                    d.ctrl0[intc_pkg::GIE_BIT] = 1'b0;
                    d.irq_req = 1'b0;
                    d.st = intc_pkg::ST_SERV;
                end else begin
                    d.vec = win;
                end
            end
            intc_pkg::ST_SERV: begin
                d.st = intc_pkg::ST_IDLE;
            end
            default: begin
                d.st = intc_pkg::ST_IDLE;
                d.irq_req = 1'b0;
            end
        endcase

        // Read data, one cycle later
        d.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                intc_pkg::A_EDGE: d.rdata = q.edge_r;
                intc_pkg::A_CTRL0: d.rdata = q.ctrl0;
                intc_pkg::A_CTRL1: d.rdata = q.ctrl1;
                intc_pkg::A_CTRL2: d.rdata = q.ctrl2;
                intc_pkg::A_CTRL3: d.rdata = q.ctrl3;
                intc_pkg::A_MULTI: d.rdata = q.multi;
                intc_pkg::A_SUPPLY: d.rdata = q.supply;
                default: d.rdata = 8'h00;
            endcase
        end
    end

    // Wake when hardware sets flags, unless any flag it sets this cycle was already set
    logic wake_q;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i)
            wake_q <= 1'b0;
        else
            wake_q <= |{newf0, newf1, newf2, newf3, newfm}
                & ~|({q.ctrl0, q.ctrl1, q.ctrl2, q.ctrl3, q.multi}
                & {newf0, newf1, newf2, newf3, newfm});
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.st <= intc_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign irq_req_o = q.irq_req;
    assign irq_vec_o = q.vec;
    assign detector_on_o = q.det_on;
    assign bandgap_en_o = q.bandgap_en;
    assign threshold_sel_o = q.supply[2:0];
    assign wake_o = wake_q;
endmodule

/* tb/cpu_seq_model.sv */
// CPU sequencer model: takes a presented vector after a latency.
// Assumes registered request from the controller on clock_i.
`timescale 1ns/1ns
module cpu_seq_model (
    input wire logic clock_i, // System clock
    input wire logic req_i, // Request seen
    input wire logic [3:0] lat_i, // Cycles before taking
    output logic ack_o // Take pulse
);
    logic [3:0] cnt = 4'h0;
    initial ack_o = 1'b0;
    always @(posedge clock_i) begin
        ack_o <= req_i && !ack_o && cnt >= lat_i;
        cnt <= req_i && !ack_o ? cnt + 4'h1 : 4'h0;
    end
endmodule

/* tb/intc_supply_assertions.sv */
// Port assertions for intc_supply.
// Assumes it is bound to the design and sees only its ports.
`timescale 1ns/1ns
module intc_supply_assertions (
    input wire logic clock_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic [2:0] addr_i, // Address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write
    input wire logic rd_i, // Read
    input wire logic [7:0] rdata_o, // Read data
    input wire logic stack_full_i, // Stack full
    input wire logic ack_i, // Taken
    input wire logic irq_req_o, // Request
    input wire logic sleep_i, // Sleep
    input wire logic low_supply_reset_en_i, // Low reset
    input wire logic bandgap_en_o, // Bandgap
    input wire logic detector_on_o, // Detector
    input wire logic [2:0] threshold_sel_o // Threshold
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence taken_s;
        ack_i && irq_req_o;
    endsequence
    sequence sup_wr_s;
        wr_i && addr_i == intc_pkg::A_SUPPLY;
    endsequence
    unmapped_rd_a: assert property (
        rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00) else $error("unmapped");
    edge_rsvd_a: assert property (
        rd_i && addr_i == intc_pkg::A_EDGE |=> rdata_o[7:4] == 4'h0)
        else $error("edge reserved bits");
    supply_rsvd_a: assert property (
        rd_i && addr_i == intc_pkg::A_SUPPLY |=> rdata_o[7:6] == 2'h0)
        else $error("supply reserved bits");
    ack_drop_a: assert property (taken_s |-> ##[1:2] !irq_req_o)
        else $error("request kept after take");
    gie_hold_a: assert property (
        taken_s ##1 (!wr_i) [*4] |-> !irq_req_o) else $error("gie not off");
    stack_block_a: assert property (
        stack_full_i [*2] |-> !irq_req_o) else $error("request when full");
    sleep_off_a: assert property (sleep_i |=> !detector_on_o)
        else $error("detector on in sleep");
    bandgap_lvr_a: assert property (
        low_supply_reset_en_i |=> bandgap_en_o) else $error("bandgap off");
    thresh_sel_a: assert property (sup_wr_s ##1 !sup_wr_s |-> ##1
        threshold_sel_o == $past(wdata_i[2:0], 2)) else $error("threshold");
endmodule
bind intc_supply intc_supply_assertions u_chk (.*);

/* tb/test_intc_supply.sv */
// Self-checking bench for intc_supply with a CPU sequencer model.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ns
module test_intc_supply;
    localparam int DLY = 10;
    logic clk = 0, rst = 1, wr = 0, rd = 0, p0 = 0, p1 = 0, c0 = 0;
    logic below = 0, slp = 0, low_supply_reset = 0, full = 0, ack, req, on, bg, wk;
    logic [2:0] addr = 3'h0, thr;
    logic [7:0] wd = 8'h00, rdat, v;
    logic [3:0] vec, lat = 4'h0;
    logic [31:0] seed = 32'h24B1;
    int num_errors = 0, n_tests = 0;
    int exp_q[$];
    always #25 clk = ~clk;
    intc_supply #(.DELAY_CYC(DLY)) u_dut (.clock_i(clk), .sys_rst_i(rst),
        .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
        .ext_irq_pin_0_i(p0), .ext_irq_pin_1_i(p1), .line_comp0_evt_i(c0),
        .ctrl1_evt_i(8'h00), .ctrl2_evt_i(8'h00), .ctrl3_evt_i(3'h0),
        .multi_evt_i(3'h0), .comp_below_i(below), .sleep_i(slp),
        .low_supply_reset_en_i(low_supply_reset), .stack_full_i(full), .ack_i(ack),
        .irq_req_o(req), .irq_vec_o(vec), .detector_on_o(on),
        .bandgap_en_o(bg), .threshold_sel_o(thr), .wake_o(wk));
    cpu_seq_model u_cpu (.clock_i(clk), .req_i(req), .lat_i(lat),
        .ack_o(ack));
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input string n, input logic [7:0] g, e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e,
        input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #10 v = rdat;
        chk(n, v, e);
    endtask
    task automatic pin(input int p, input logic l);
        @(posedge clk);
        if (p == 1) p1 <= l;
        else p0 <= l;
        repeat (3) @(posedge clk);
    endtask
    task automatic wait_ack();
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            if (ack === 1'b1) return;
        end
        num_errors++;
        end_of_test();
    endtask
    // Each take is compared with the next expected vector
    always @(posedge clk) begin
        if (ack === 1'b1) begin
            v = exp_q.size() > 0 ? 8'(exp_q.pop_front()) : 8'hFF;
            chk("vector", {4'h0, vec}, v);
        end
    end
    initial begin
        exp_q = '{0, 1, 5};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rchk(3'(a), 8'h00, "reset");
        repeat (6) begin
            v = xs();
            wr_reg(intc_pkg::A_EDGE, v);
            rchk(intc_pkg::A_EDGE, v & 8'h0F, "edge");
        end
        wr_reg(intc_pkg::A_CTRL0, 8'hFE);
        rchk(intc_pkg::A_CTRL0, 8'h7E, "ctrl0");
        chk("masked", {7'h0, req}, 8'h00);
        wr_reg(intc_pkg::A_SUPPLY, 8'hFF);
        rchk(intc_pkg::A_SUPPLY, 8'h1F, "supply");
        chk("thr", {5'h0, thr}, 8'h07);
        chk("on", {7'h0, on}, 8'h01);
        chk("bandgap", {7'h0, bg}, 8'h01);
        for (int p = 0; p < 2; p++) for (int c = 0; c < 4; c++) begin
            wr_reg(intc_pkg::A_EDGE, 8'(c << (2 * p)));
            wr_reg(intc_pkg::A_CTRL0, 8'h00);
            pin(p, 1'b1);
            rchk(intc_pkg::A_CTRL0, 8'(c % 2) << (5 + p), "rise");
            wr_reg(intc_pkg::A_CTRL0, 8'h00);
            pin(p, 1'b0);
            rchk(intc_pkg::A_CTRL0, 8'(c / 2) << (5 + p), "fall");
        end
        wr_reg(intc_pkg::A_CTRL0, 8'h00);
        c0 <= 1'b1;
        @(posedge clk);
        c0 <= 1'b0;
        #1 chk("wake", {7'h0, wk}, 8'h01);
        rchk(intc_pkg::A_CTRL0, 8'h10, "comp0");
        wr_reg(intc_pkg::A_EDGE, 8'h0F);
        wr_reg(intc_pkg::A_CTRL0, 8'h0D);
        full <= 1'b1;
        p0 <= 1'b1;
        p1 <= 1'b1;
        repeat (8) @(posedge clk);
        chk("stack", {7'h0, req}, 8'h00);
        full <= 1'b0;
        wait_ack();
        repeat (4) @(posedge clk);
        chk("gie off", {7'h0, req}, 8'h00);
        rchk(intc_pkg::A_CTRL0, 8'h6C, "pending");
        lat <= 4'h5;
        wr_reg(intc_pkg::A_CTRL0, 8'h4D);
        wait_ack();
        wr_reg(intc_pkg::A_CTRL1, 8'h02);
        wr_reg(intc_pkg::A_CTRL0, 8'h01);
        wr_reg(intc_pkg::A_SUPPLY, 8'h13);
        repeat (4) @(posedge clk);
        repeat (4) begin
            below <= 1'b1;
            repeat (3) @(posedge clk);
            below <= 1'b0;
            @(posedge clk);
        end
        rchk(intc_pkg::A_CTRL1, 8'h02, "chatter");
        below <= 1'b1;
        rchk(intc_pkg::A_SUPPLY, 8'h33, "low flag");
        wait_ack();
        slp <= 1'b1;
        repeat (3) @(posedge clk);
        chk("sleep", {7'h0, on}, 8'h00);
        wr_reg(intc_pkg::A_SUPPLY, 8'h00);
        low_supply_reset <= 1'b1;
        repeat (3) @(posedge clk);
        chk("lvr bandgap", {7'h0, bg}, 8'h01);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(intc_pkg::A_CTRL0, 8'h00, "rerst");
        chk("vectors left", 8'(exp_q.size()), 8'h00);
        end_of_test();
    end
endmodule
